// file: verilog/cqr_regs.vh
// Constants for the camera query command responder.
// Assumes inclusion by bare name from design files.
`ifndef CQR_REGS_VH
`define CQR_REGS_VH
// ==========================================================
// Command codes
`define CQR_CMD_VENDOR 8'h01
`define CQR_CMD_MODEL 8'h02
`define CQR_CMD_PRODID 8'h03
`define CQR_CMD_MCU_VER 8'h40
`define CQR_CMD_FPGA_VER 8'h41
// ==========================================================
// Direction flag values
`define CQR_DIR_READ 1'b1
`define CQR_DIR_RESP 1'b0
// ==========================================================
// Payload lengths
`define CQR_LEN_VER 8'h03
`define CQR_LEN_STR 8'h10
// ==========================================================
// Fixed filler byte and reset values
`define CQR_FILL_BYTE 8'h00
`define CQR_RST_BYTE 8'h00
`endif

// file: verilog/cqr_decode.v
// Command decoder for the query responder.
// Assumes a registered frame header from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cqr_regs.vh"
module cqr_decode (
  input wire [7:0] i_code,
  input wire i_dir,
  output reg o_known,
  output reg [7:0] o_len,
  output reg [2:0] o_sel
);
  // ==========================================================
  // Code to payload selection
  always @* begin
    o_known = 1'b0;
    o_len = 8'h00;
    o_sel = 3'd0;
    if (i_dir == `CQR_DIR_READ) begin
      case (i_code)
        `CQR_CMD_MCU_VER: begin
          o_known = 1'b1;
          o_len = `CQR_LEN_VER;
          o_sel = 3'd0;
        end
        `CQR_CMD_FPGA_VER: begin
          o_known = 1'b1;
          o_len = `CQR_LEN_VER;
          o_sel = 3'd1;
        end
        `CQR_CMD_VENDOR: begin
          o_known = 1'b1;
          o_len = `CQR_LEN_STR;
          o_sel = 3'd2;
        end
        `CQR_CMD_MODEL: begin
          o_known = 1'b1;
          o_len = `CQR_LEN_STR;
          o_sel = 3'd3;
        end
        `CQR_CMD_PRODID: begin
          o_known = 1'b1;
          o_len = `CQR_LEN_STR;
          o_sel = 3'd4;
        end
        default: begin
          o_known = 1'b0;
        end
      endcase
    end
  end
endmodule // cqr_decode
`default_nettype wire

// file: verilog/cqr_responder.v
// Query responder: takes a decoded command header, streams back a
// response header and payload bytes.
// Only the five read-only queries are answered; all else is dropped.
// Payload is captured whole at the header, so version and string
// inputs may change freely once the header has been shown.
// Limitation: a query shown while busy is lost, not queued, so the
// host side must wait for o_busy low before the next one.
// Clock enable low holds every register, outputs included.
// Assumes the serial transport outside frames bytes on the same clock,
// presents each header for one cycle with i_cmd_valid, and drives
// i_tx_ready as a level that may stall any byte for any length of time.
`timescale 1ns/1ps
`default_nettype none
`include "cqr_regs.vh"
// Contract
// - Queries arrive with direction 1 and no data; answers carry the same code, direction 0 and the fixed length.
// - Code 0x40 answers three bytes, low then high byte of the controller firmware version in BCD.
// - The third byte of the 0x40 answer is the protocol version in BCD.
// - Code 0x41 answers three bytes, low then high byte of the logic firmware version in BCD.
// - The third byte of the 0x41 answer is always 0x00.
// - Code 0x01 answers a 16-byte vendor name string.
// - The vendor string is zero-terminated if shorter than 16 and unterminated if full.
// - Code 0x02 answers a 16-byte model string, zero-terminated unless it fills all 16.
// - Code 0x03 answers a 16-byte product identification string.
// - The product string is zero-terminated if shorter than 16 and unterminated if full.
module cqr_responder (
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_code,
  input wire i_cmd_dir,
  input wire [15:0] i_mcu_ver,
  input wire [7:0] i_proto_ver,
  input wire [15:0] i_fpga_ver,
  input wire [127:0] i_vendor_str,
  input wire [127:0] i_model_str,
  input wire [127:0] i_prodid_str,
  input wire i_tx_ready,
  output reg o_busy,
  output reg o_hdr_valid,
  output reg [7:0] o_rsp_code,
  output reg o_rsp_dir,
  output reg [7:0] o_rsp_len,
  output reg o_byte_valid,
  output reg [7:0] o_byte,
  output reg o_byte_last
);
  // ==========================================================
  // States, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HDR = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;
  // One-hot keeps each state test to a single flip-flop

  // ==========================================================
  // Registered state and internal nets
  reg [2:0] state_r;
  reg [7:0] code_r;
  reg [2:0] sel_r;
  reg [7:0] len_r;
  reg [7:0] idx_r;
  reg [127:0] pay_r;
  wire dec_known;
  wire [7:0] dec_len;
  wire [2:0] dec_sel;
  wire byte_take;
  wire [7:0] idx_inc;
  wire cmd_take;
  // Payload unpacked into bytes for the output mux
  wire [7:0] pay_byte [0:15];
  genvar g;

  // Decoder looks only at the incoming header
  cqr_decode u_dec (
    .i_code(i_cmd_code),
    .i_dir(i_cmd_dir),
    .o_known(dec_known),
    .o_len(dec_len),
    .o_sel(dec_sel)
  );

  // ==========================================================
  // Zero-terminate a string: bytes after first zero forced to zero
  function [127:0] str_fix;
    input [127:0] s;
    integer k;
    reg seen;
    begin
      seen = 1'b0;
      str_fix = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      for (k = 0; k < 16; k = k + 1) begin
        // Once a zero is seen the rest of the string reads as zero
        if (s[k*8 +: 8] == 8'h00) begin
          seen = 1'b1;
        end
        str_fix[k*8 +: 8] = seen ? 8'h00 : s[k*8 +: 8];
      end
    end
  endfunction

  // ==========================================================
  // Last-byte test, shared by the header and data states
  // Kept as a function so both paths agree on the end point
  function last_at;
    input [7:0] idx;
    input [7:0] len;
    begin
      last_at = (idx == len - 8'h01);
    end
  endfunction

  // Byte accepted when downstream is ready
  assign byte_take = o_byte_valid && i_tx_ready;
  // Index wraps at 8 bits but never passes 15 for any length used
  assign idx_inc = idx_r + 8'h01;
  // New query only from idle; busy commands are simply not seen
  assign cmd_take = (state_r == ST_IDLE) && i_cmd_valid && dec_known;

  // ==========================================================
  // Payload byte lanes
  // A fixed lane per byte keeps the output mux a plain 16-way select
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_lane
      assign pay_byte[g] = pay_r[g*8 +: 8];
    end
  endgenerate

  // ==========================================================
  // Control and output registers
  always @(posedge i_mclk) begin
    if (i_rst) begin
      // Reset wins over the clock enable; every output goes quiet
      state_r <= ST_IDLE;
      code_r <= `CQR_RST_BYTE;
      sel_r <= 3'd0;
      len_r <= `CQR_RST_BYTE;
      idx_r <= `CQR_RST_BYTE;
      pay_r <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      o_busy <= 1'b0;
      o_hdr_valid <= 1'b0;
      o_rsp_code <= `CQR_RST_BYTE;
      o_rsp_dir <= `CQR_DIR_RESP;
      o_rsp_len <= `CQR_RST_BYTE;
      o_byte_valid <= 1'b0;
      o_byte <= `CQR_RST_BYTE;
      o_byte_last <= 1'b0;
    end else if (i_ce) begin
      // Low enable skips this branch, so every register holds
      // Idle takes a query, header shows it, data streams it
      case (state_r)
        ST_IDLE: begin
          if (cmd_take) begin
            code_r <= i_cmd_code;
            sel_r <= dec_sel;
            len_r <= dec_len;
            idx_r <= 8'h00;
            // Snapshot payload so mid-answer changes cannot tear it
            case (dec_sel)
              3'd0: pay_r <= {104'h0, i_proto_ver, i_mcu_ver[15:8], i_mcu_ver[7:0]};
              3'd1: pay_r <= {104'h0, `CQR_FILL_BYTE, i_fpga_ver[15:8], i_fpga_ver[7:0]};
              3'd2: pay_r <= str_fix(i_vendor_str);
              3'd3: pay_r <= str_fix(i_model_str);
              3'd4: pay_r <= str_fix(i_prodid_str);
              default: pay_r <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
            endcase
            o_rsp_code <= i_cmd_code;
            o_rsp_dir <= `CQR_DIR_RESP;
            o_rsp_len <= dec_len;
            // Busy rises with the header and falls with the last byte
            o_hdr_valid <= 1'b1;
            o_busy <= 1'b1;
            state_r <= ST_HDR;
          end
        end
        ST_HDR: begin
          // Header shown one cycle, then first byte
          o_hdr_valid <= 1'b0;
          o_byte_valid <= 1'b1;
          // Header fields stand until the next answer
          o_byte <= pay_byte[0];
          o_byte_last <= last_at(8'h00, len_r);
          state_r <= ST_DATA;
        end
        ST_DATA: begin
          // A stalled byte stands until it is taken
          if (byte_take) begin
            if (o_byte_last) begin
              // Last byte taken, back to idle
              o_byte_valid <= 1'b0;
              o_byte_last <= 1'b0;
              o_busy <= 1'b0;
              state_r <= ST_IDLE;
            end else begin
              // Advance to the next lane
              idx_r <= idx_inc;
              o_byte <= pay_byte[idx_inc[3:0]];
              o_byte_last <= last_at(idx_inc, len_r);
            end
          end
        end
        default: begin
          // Illegal state code: recover to idle with busy, header valid and byte valid low
          state_r <= ST_IDLE;
          o_busy <= 1'b0;
          o_hdr_valid <= 1'b0;
          o_byte_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule // cqr_responder
`default_nettype wire

// file: verification/cqr_sink.sv
// Byte sink standing for the host end of the link.
// Assumes the responder clock; slow mode stalls every other cycle.
`timescale 1ns/1ps
`default_nettype none
module cqr_sink (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_slow,
  output logic o_ready
);
  // ====
  // Ready pattern, stalls to test byte hold
  always @(posedge i_mclk) begin
    o_ready <= i_rst | ~i_slow | ~o_ready;
  end
endmodule // cqr_sink
`default_nettype wire

// file: verification/cqr_responder_checker.sv
// Port assertions for the query responder.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cqr_checker (
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_code,
  input wire i_cmd_dir,
  input wire [15:0] i_mcu_ver,
  input wire i_tx_ready,
  input wire o_busy,
  input wire o_hdr_valid,
  input wire [7:0] o_rsp_code,
  input wire o_rsp_dir,
  input wire [7:0] o_rsp_len,
  input wire o_byte_valid,
  input wire [7:0] o_byte,
  input wire o_byte_last
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // ====
  // Query taken while idle
  sequence s_take;
    i_ce && !o_busy && i_cmd_valid && i_cmd_dir
      && (i_cmd_code inside {8'h01, 8'h02, 8'h03, 8'h40, 8'h41});
  endsequence
  sequence s_answer;
    o_hdr_valid && !o_rsp_dir;
  endsequence
  chk_hdr_after_take: assert property (s_take
    |=> s_answer ##0 o_rsp_code == $past(i_cmd_code))
    else $error("missing answer header");
  chk_write_ignored: assert property (i_ce && !o_busy && i_cmd_valid && !i_cmd_dir |=> !o_hdr_valid)
    else $error("write frame answered");
  chk_len_version: assert property (o_hdr_valid && o_rsp_code[6] |-> o_rsp_len == 8'h03)
    else $error("version length wrong");
  chk_len_string: assert property (o_hdr_valid && !o_rsp_code[6] |-> o_rsp_len == 8'h10)
    else $error("string length wrong");
  chk_mcu_low: assert property (o_hdr_valid && i_ce && o_rsp_code == 8'h40
    |=> o_byte_valid && o_byte == i_mcu_ver[7:0])
    else $error("first version byte wrong");
  chk_fpga_pad: assert property (o_byte_valid && o_byte_last && o_rsp_code == 8'h41 |-> o_byte == 8'h00)
    else $error("filler byte not zero");
  chk_stall_hold: assert property (o_byte_valid && !i_tx_ready && i_ce |=> o_byte_valid && $stable(o_byte))
    else $error("byte dropped in stall");
  chk_busy_span: assert property (o_byte_valid |-> o_busy)
    else $error("byte outside busy");
endmodule // cqr_checker
bind cqr_responder cqr_checker u_chk (.i_mclk, .i_rst, .i_ce, .i_cmd_valid, .i_cmd_code,
  .i_cmd_dir, .i_mcu_ver, .i_tx_ready, .o_busy, .o_hdr_valid, .o_rsp_code, .o_rsp_dir,
  .o_rsp_len, .o_byte_valid, .o_byte, .o_byte_last);
`default_nettype wire

// file: verification/test_camera_query_command_responder.sv
// Testbench for the query responder.
// Assumes sink model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_camera_query_command_responder;
  logic i_mclk = 0, i_rst = 1, i_cmd_valid = 0, i_cmd_dir = 0, slow = 0, ce = 1;
  logic [7:0] i_cmd_code = 8'h00;
  logic [127:0] ven = 128'h5A5A_5A00_4E56, pid = 128'h0031_3233;
  logic [127:0] mdl = 128'h4847_4645_4443_4241_4847_4645_4443_4241;
  wire i_tx_ready, o_busy, o_hdr_valid, o_rsp_dir, o_byte_valid, o_byte_last;
  wire [7:0] o_rsp_code, o_rsp_len, o_byte;
  int fails = 0, checked = 0, cyc = 0;
  // ====
  // Version inputs fixed; clock enable driven by the bench
  cqr_responder dut (.i_mclk, .i_rst, .i_ce(ce), .i_cmd_valid, .i_cmd_code,
    .i_cmd_dir, .i_mcu_ver(16'h0123), .i_proto_ver(8'h12), .i_fpga_ver(16'h0456),
    .i_vendor_str(ven), .i_model_str(mdl), .i_prodid_str(pid), .i_tx_ready,
    .o_busy, .o_hdr_valid, .o_rsp_code, .o_rsp_dir, .o_rsp_len, .o_byte_valid,
    .o_byte, .o_byte_last);
  cqr_sink u_sink (.i_mclk, .i_rst, .i_slow(slow), .o_ready(i_tx_ready));
  initial forever #10 i_mclk = ~i_mclk;
  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] code, input logic dir);
    @(posedge i_mclk);
    i_cmd_valid <= 1;
    i_cmd_code <= code;
    i_cmd_dir <= dir;
    @(posedge i_mclk);
    i_cmd_valid <= 0;
  endtask
  // Gather the payload as the sink accepts it, then compare it whole
  task automatic gather(input logic [7:0] len, input logic [127:0] exp);
    int k;
    logic [127:0] got;
    k = 0;
    got = '0;
    while (k < len && cyc < 3000) begin
      @(negedge i_mclk);
      if (o_byte_valid && i_tx_ready && ce) begin
        got[8*k +: 8] = o_byte;
        if (k == len - 1) chk(o_byte_last, 1);
        k++;
      end
    end
    chk(got, exp);
  endtask
  // Query, check the answer header, then take the payload
  task automatic xfer(input logic [7:0] code, input logic [7:0] len, input logic [127:0] exp);
    send(code, 1'b1);
    @(negedge i_mclk);
    chk({o_hdr_valid, o_rsp_code, o_rsp_dir, o_rsp_len}, {1'b1, code, 1'b0, len});
    gather(len, exp);
  endtask
  task automatic t_versions;
    xfer(8'h40, 8'h03, 128'h0012_0123);
    @(negedge i_mclk) slow = 1;
    xfer(8'h41, 8'h03, 128'h0456);
  endtask
  // Vendor has junk after its zero, model is full
  task automatic t_strings;
    xfer(8'h01, 8'h10, 128'h4E56);
    xfer(8'h02, 8'h10, mdl);
    xfer(8'h03, 8'h10, pid);
  endtask
  // A write frame and an unknown code both go unanswered
  task automatic t_write;
    send(8'h01, 1'b0);
    send(8'h04, 1'b1);
    repeat (3) begin
      @(negedge i_mclk);
      chk({o_hdr_valid, o_busy}, 0);
    end
    xfer(8'h03, 8'h10, pid);
  endtask
  // Enable low right after the take: header stands, no byte moves
  task automatic t_ce;
    send(8'h40, 1'b1);
    ce <= 0;
    repeat (3) begin
      @(negedge i_mclk);
      chk({o_hdr_valid, o_byte_valid, o_busy}, 3'b101);
    end
    @(posedge i_mclk);
    ce <= 1;
    gather(8'h03, 128'h0012_0123);
  endtask
  // A second query while busy is lost; the first answer runs on
  task automatic t_busy;
    int n;
    n = 0;
    send(8'h01, 1'b1);
    send(8'h41, 1'b1);
    @(negedge i_mclk);
    chk({o_hdr_valid, o_busy, o_rsp_code}, {2'b01, 8'h01});
    while (o_busy && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    repeat (3) begin
      @(negedge i_mclk);
      chk({o_hdr_valid, o_busy, o_rsp_code}, {2'b00, 8'h01});
    end
  endtask
  task automatic test_done;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 0;
    t_versions;
    t_strings;
    t_ce;
    t_busy;
    t_write;
    test_done;
  end
endmodule // test_camera_query_command_responder
`default_nettype wire
